// ---- pkg/move_pkg.sv ----
// Operation
// - a load through an address register plus a long displacement takes code size 7 and 4 cycles.
// - a load from the stack pointer plus a short displacement takes code size 5 and 3 cycles.
// - a load from the stack pointer plus a long displacement takes code size 7 and 4 cycles.
// - a load from the io window base plus an io offset takes code size 4 and 2 cycles.
// - a store through an address register plus a long displacement takes code size 7 and 4 cycles.
// - a store to the stack pointer plus a short displacement takes code size 5 and 3 cycles.
// - a store to the stack pointer plus a long displacement takes code size 7 and 4 cycles.
// - a store to the io window base plus an io offset takes code size 4 and 2 cycles.
// - an immediate stored to the io window takes code size 6 and 3 cycles.
// - an immediate stored to a 12-bit absolute address takes code size 7 and 3 cycles.
// - a word load from stack pointer plus short displacement into a wide pair takes size 5 and 4 cycles.
// - a word load from stack pointer plus short displacement into an address register takes size 5, 4 cycles.
// - a word store of a wide pair to stack pointer plus short displacement takes size 5 and 4 cycles.
// - a word store of an address register to stack pointer plus long displacement takes size 7, 5 cycles.
package move_pkg;

   // ************************************************************
   // operation classes
   // ************************************************************
   typedef enum {
      OP_NONE, OP_LD_AD16, OP_LD_SP8, OP_LD_SP16, OP_LD_IO, OP_ST_AD16,
      OP_ST_SP8, OP_ST_SP16, OP_ST_IO, OP_IMM_IO, OP_IMM_ABSOLUTE_MID,
      OP_LDW_SP8_DW, OP_LDW_SP8_A, OP_STW_SP8_DW, OP_STW_SP16_A,
      OP_IMMW_DW, OP_IMMW_A, OP_TO_FLAGS
   } op_class_t;

   typedef struct packed {
      logic [3:0] code_size;
      logic [2:0] cycles;
   } op_cost_t;

   typedef struct packed {
      logic        req;
      logic        write;
      logic        word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_t;

   // ************************************************************
   // code sizes and cycle counts
   // ************************************************************
   localparam logic [3:0] SIZE_3 = 4'h3;
   localparam logic [3:0] SIZE_4 = 4'h4;
   localparam logic [3:0] SIZE_5 = 4'h5;
   localparam logic [3:0] SIZE_6 = 4'h6;
   localparam logic [3:0] SIZE_7 = 4'h7;
   localparam logic [2:0] CYC_2  = 3'h2;
   localparam logic [2:0] CYC_3  = 3'h3;
   localparam logic [2:0] CYC_4  = 3'h4;
   localparam logic [2:0] CYC_5  = 3'h5;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [3:0]  RST_FLAGS = 4'h0;
   localparam logic [15:0] RST_IO_BASE = 16'h3f00;

endpackage

// ---- hdl/move_classify.sv ----
`timescale 1ns/1ps
// ************************************************************
// opcode classifier: two opcode bytes to class and cost
// ************************************************************
module move_classify (
   input  wire logic [7:0]          op0,
   input  wire logic [7:0]          op1,
   output move_pkg::op_class_t      op_class,
   output move_pkg::op_cost_t       cost
);

   // byte pattern decode
   always_comb begin
      op_class = move_pkg::OP_NONE;
      cost     = '{code_size: 4'h0, cycles: 3'h0};
      if (op0 == 8'h26 && op1[3]) begin
         op_class = move_pkg::OP_LD_AD16;
         cost = '{move_pkg::SIZE_7, move_pkg::CYC_4};
      end else if (op0 == 8'h26 && op1[3:2] == 2'b01) begin
         op_class = move_pkg::OP_LD_SP8;
         cost = '{move_pkg::SIZE_5, move_pkg::CYC_3};
      end else if (op0 == 8'h26 && op1[3:2] == 2'b00) begin
         op_class = move_pkg::OP_LD_SP16;
         cost = '{move_pkg::SIZE_7, move_pkg::CYC_4};
      end else if (op0 == 8'h27 && op1[3]) begin
         op_class = move_pkg::OP_ST_AD16;
         cost = '{move_pkg::SIZE_7, move_pkg::CYC_4};
      end else if (op0 == 8'h27 && op1[3:2] == 2'b01) begin
         op_class = move_pkg::OP_ST_SP8;
         cost = '{move_pkg::SIZE_5, move_pkg::CYC_3};
      end else if (op0 == 8'h27 && op1[3:2] == 2'b00) begin
         op_class = move_pkg::OP_ST_SP16;
         cost = '{move_pkg::SIZE_7, move_pkg::CYC_4};
      end else if (op0 == 8'h2e && op1[3:1] == 3'b011) begin
         op_class = move_pkg::OP_LDW_SP8_DW;
         cost = '{move_pkg::SIZE_5, move_pkg::CYC_4};
      end else if (op0 == 8'h2e && op1[3:1] == 3'b010) begin
         op_class = move_pkg::OP_LDW_SP8_A;
         cost = '{move_pkg::SIZE_5, move_pkg::CYC_4};
      end else if (op0 == 8'h2f && op1[3:1] == 3'b011) begin
         op_class = move_pkg::OP_STW_SP8_DW;
         cost = '{move_pkg::SIZE_5, move_pkg::CYC_4};
      end else if (op0 == 8'h2f && op1[3:1] == 3'b000) begin
         op_class = move_pkg::OP_STW_SP16_A;
         cost = '{move_pkg::SIZE_7, move_pkg::CYC_5};
      end else if (op0 == 8'h29 && op1[3:2] == 2'b01) begin
         op_class = move_pkg::OP_TO_FLAGS;
         cost = '{move_pkg::SIZE_3, move_pkg::CYC_3};
      end else if (op0[7:2] == 6'b0110_00) begin
         op_class = move_pkg::OP_LD_IO;
         cost = '{move_pkg::SIZE_4, move_pkg::CYC_2};
      end else if (op0[7:2] == 6'b0111_00) begin
         op_class = move_pkg::OP_ST_IO;
         cost = '{move_pkg::SIZE_4, move_pkg::CYC_2};
      end else if (op0 == 8'h02) begin
         op_class = move_pkg::OP_IMM_IO;
         cost = '{move_pkg::SIZE_6, move_pkg::CYC_3};
      end else if (op0 == 8'h15) begin
         op_class = move_pkg::OP_IMM_ABSOLUTE_MID;
         cost = '{move_pkg::SIZE_7, move_pkg::CYC_3};
      end else if (op0[7:1] == 7'b0000_110) begin
         op_class = move_pkg::OP_IMMW_DW;
         cost = '{move_pkg::SIZE_4, move_pkg::CYC_2};
      end else if (op0[7:1] == 7'b0000_111) begin
         op_class = move_pkg::OP_IMMW_A;
         cost = '{move_pkg::SIZE_4, move_pkg::CYC_2};
      end
   end

endmodule

// ---- hdl/byte_word_move_decoder.sv ----
`timescale 1ns/1ps
// ************************************************************
// data-transfer execute unit
// ************************************************************
module byte_word_move_decoder (
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   input  wire logic                start,
   input  wire logic [7:0]          op0,
   input  wire logic [7:0]          op1,
   input  wire logic [15:0]         operand,
   input  wire logic [7:0]          imm,
   input  wire logic [15:0]         stack_pointer,
   input  wire logic [15:0]         io_window_base,
   input  wire logic [15:0]         rdata,
   output move_pkg::mem_req_t       mem,
   output logic                     busy,
   output logic                     done,
   output logic [3:0]               code_size,
   output logic [7:0]               data_reg0,
   output logic [7:0]               data_reg1,
   output logic [7:0]               data_reg2,
   output logic [7:0]               data_reg3,
   output logic [15:0]              addr_reg0,
   output logic [15:0]              addr_reg1,
   output logic [3:0]               flag_word
);

   // register file kept here
   logic [7:0]  dreg [0:3];
   logic [15:0] areg [0:1];
   logic [7:0]  next_dreg [0:3];
   logic [15:0] next_areg [0:1];
   logic [3:0]  next_flag_word;

   move_pkg::op_class_t op_class;
   move_pkg::op_cost_t  cost;
   move_pkg::op_class_t cur;
   move_pkg::op_class_t next_cur;
   logic [2:0]  count;
   logic [2:0]  next_count;
   logic [1:0]  reg_sel;
   logic [1:0]  next_reg_sel;
   logic        next_busy;
   logic        next_done;
   logic [3:0]  next_code_size;
   move_pkg::mem_req_t next_mem;

   move_classify u_cls (
      .op0      (op0),
      .op1      (op1),
      .op_class (op_class),
      .cost     (cost)
   );

   // sign extension helper
   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction

   // wide pair read from two data registers
   function automatic logic [15:0] pair(input logic [7:0] lo, input logic [7:0] hi);
      pair = {hi, lo};
   endfunction

   // immediate widened once for the wide pair
   logic [15:0] imm_wide;
   assign imm_wide = sext8(imm);

   logic [1:0] dst_data_reg;
   logic [1:0] src_data_reg;
   logic       src_addr_reg;
   logic       dst_addr_reg;
   logic       src_wide_pair;
   logic       dst_wide_pair;
   assign dst_data_reg  = op1[1:0];
   assign src_data_reg  = op1[1:0];
   assign src_addr_reg  = op1[2];
   assign dst_addr_reg  = op1[0];
   assign src_wide_pair = op1[0];
   assign dst_wide_pair = op1[0];

   // sequencing, bus request and writeback
   always_comb begin
      next_cur       = cur;
      next_count     = count;
      next_reg_sel   = reg_sel;
      next_busy      = busy;
      next_done      = 1'b0;
      next_code_size = code_size;
      next_mem       = mem;
      next_flag_word = flag_word;
      for (int i = 0; i < 4; i++) begin
         next_dreg[i] = dreg[i];
      end
      for (int i = 0; i < 2; i++) begin
         next_areg[i] = areg[i];
      end
      next_mem.req = 1'b0;
      if (!busy) begin
         if (start && op_class != move_pkg::OP_NONE) begin
            next_cur       = op_class;
            next_count     = cost.cycles - 3'h1;
            next_code_size = cost.code_size;
            next_busy      = 1'b1;
            next_reg_sel   = dst_data_reg;
            next_mem       = '{1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000};
            case (op_class)
               move_pkg::OP_LD_AD16:    next_mem.addr = areg[src_addr_reg] + operand;
               move_pkg::OP_LD_SP8:     next_mem.addr = stack_pointer + {8'h00, operand[7:0]};
               move_pkg::OP_LD_SP16:    next_mem.addr = stack_pointer + operand;
               move_pkg::OP_LD_IO:      next_mem.addr = io_window_base + {8'h00, operand[7:0]};
               move_pkg::OP_ST_AD16: begin
                  next_mem.write = 1'b1;
                  next_mem.addr  = areg[op1[2]] + operand;
                  next_mem.wdata = {8'h00, dreg[src_data_reg]};
               end
               move_pkg::OP_ST_SP8: begin
                  next_mem.write = 1'b1;
                  next_mem.addr  = stack_pointer + {8'h00, operand[7:0]};
                  next_mem.wdata = {8'h00, dreg[src_data_reg]};
               end
               move_pkg::OP_ST_SP16: begin
                  next_mem.write = 1'b1;
                  next_mem.addr  = stack_pointer + operand;
                  next_mem.wdata = {8'h00, dreg[src_data_reg]};
               end
               move_pkg::OP_ST_IO: begin
                  next_mem.write = 1'b1;
                  next_mem.addr  = io_window_base + {8'h00, operand[7:0]};
                  next_mem.wdata = {8'h00, dreg[op0[1:0]]};
               end
               move_pkg::OP_IMM_IO: begin
                  next_mem.write = 1'b1;
                  next_mem.addr  = io_window_base + {8'h00, operand[7:0]};
                  next_mem.wdata = {8'h00, imm};
               end
               move_pkg::OP_IMM_ABSOLUTE_MID: begin
                  next_mem.write = 1'b1;
                  next_mem.addr  = {4'h0, operand[11:0]};
                  next_mem.wdata = {8'h00, imm};
               end
               move_pkg::OP_LDW_SP8_DW: begin
                  next_mem.word = 1'b1;
                  next_mem.addr = stack_pointer + {8'h00, operand[7:0]};
                  next_reg_sel  = {1'b0, dst_wide_pair};
               end
               move_pkg::OP_LDW_SP8_A: begin
                  next_mem.word = 1'b1;
                  next_mem.addr = stack_pointer + {8'h00, operand[7:0]};
                  next_reg_sel  = {1'b0, dst_addr_reg};
               end
               move_pkg::OP_STW_SP8_DW: begin
                  next_mem.write = 1'b1;
                  next_mem.word  = 1'b1;
                  next_mem.addr  = stack_pointer + {8'h00, operand[7:0]};
                  next_mem.wdata = src_wide_pair ? pair(dreg[2], dreg[3]) : pair(dreg[0], dreg[1]);
               end
               move_pkg::OP_STW_SP16_A: begin
                  next_mem.write = 1'b1;
                  next_mem.word  = 1'b1;
                  next_mem.addr  = stack_pointer + operand;
                  next_mem.wdata = areg[op1[0]];
               end
               default: begin
                  next_mem.req = 1'b0;
               end
            endcase
            if (op_class == move_pkg::OP_LD_IO || op_class == move_pkg::OP_ST_IO
                || op_class == move_pkg::OP_IMMW_DW || op_class == move_pkg::OP_IMMW_A) begin
               next_reg_sel = op0[1:0];
            end
         end
      end else if (count > 3'h1) begin
         next_count = count - 3'h1;
      end else begin
         // final cycle: write back
         next_busy  = 1'b0;
         next_done  = 1'b1;
         next_count = 3'h0;
         case (cur)
            move_pkg::OP_LD_AD16, move_pkg::OP_LD_SP8, move_pkg::OP_LD_SP16, move_pkg::OP_LD_IO:
               next_dreg[reg_sel] = rdata[7:0];
            move_pkg::OP_LDW_SP8_DW: begin
               next_dreg[{reg_sel[0], 1'b0}] = rdata[7:0];
               next_dreg[{reg_sel[0], 1'b1}] = rdata[15:8];
            end
            move_pkg::OP_LDW_SP8_A:
               next_areg[reg_sel[0]] = rdata;
            move_pkg::OP_IMMW_DW: begin
               next_dreg[{reg_sel[0], 1'b0}] = imm_wide[7:0];
               next_dreg[{reg_sel[0], 1'b1}] = imm_wide[15:8];
            end
            move_pkg::OP_IMMW_A:
               next_areg[reg_sel[0]] = {8'h00, imm};
            move_pkg::OP_TO_FLAGS:
               next_flag_word = dreg[reg_sel][3:0];
            default: begin
               next_flag_word = flag_word;
            end
         endcase
      end
   end

   // state registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cur       <= move_pkg::OP_NONE;
         count     <= 3'h0;
         reg_sel   <= 2'h0;
         busy      <= 1'b0;
         done      <= 1'b0;
         code_size <= 4'h0;
         mem       <= '{1'b0, 1'b0, 1'b0, move_pkg::RST_WORD, move_pkg::RST_WORD};
         flag_word <= move_pkg::RST_FLAGS;
         for (int i = 0; i < 4; i++) begin
            dreg[i] <= move_pkg::RST_BYTE;
         end
         for (int i = 0; i < 2; i++) begin
            areg[i] <= move_pkg::RST_WORD;
         end
      end else begin
         cur       <= next_cur;
         count     <= next_count;
         reg_sel   <= next_reg_sel;
         busy      <= next_busy;
         done      <= next_done;
         code_size <= next_code_size;
         mem       <= next_mem;
         flag_word <= next_flag_word;
         for (int i = 0; i < 4; i++) begin
            dreg[i] <= next_dreg[i];
         end
         for (int i = 0; i < 2; i++) begin
            areg[i] <= next_areg[i];
         end
      end
   end

   // register file views
   always_comb begin
      data_reg0 = dreg[0];
      data_reg1 = dreg[1];
      data_reg2 = dreg[2];
      data_reg3 = dreg[3];
      addr_reg0 = areg[0];
      addr_reg1 = areg[1];
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_ld_sp8_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_LD_SP8) |=> busy ##1 busy ##1 (!busy && done))
      else $error("short stack load cycle count wrong");
   a_ld_io_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_LD_IO) |=> busy ##1 (!busy && done))
      else $error("io load cycle count wrong");
   a_stw_a_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_STW_SP16_A) |=> busy[*4] ##1 done)
      else $error("address word store cycle count wrong");
   a_ld_ad_size: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_LD_AD16) |=> code_size == 4'h7 && mem.req && !mem.write)
      else $error("long address load size wrong");
   a_imm_io_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_IMM_IO) |=> mem.write && mem.wdata[7:0] == $past(imm))
      else $error("io immediate data wrong");
   a_absolute_mid_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_IMM_ABSOLUTE_MID) |=> mem.addr == {4'h0, $past(operand[11:0])})
      else $error("absolute address wrong");
   a_flags_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (done && cur != move_pkg::OP_TO_FLAGS) |-> $stable(flag_word))
      else $error("flags changed by move");
   a_ld_sp16_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!busy && start && op_class == move_pkg::OP_LD_SP16) |=> busy[*3] ##1 done)
      else $error("long stack load cycle count wrong");

   // instruction accepted at this edge
   logic take;
   assign take = !busy && start;

   a_st_ad_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_ST_AD16) |=> busy[*3] ##1 done)
      else $error("long address store cycle count wrong");
   a_st_sp8_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_ST_SP8) |=> busy[*2] ##1 done)
      else $error("short stack store cycle count wrong");
   a_st_sp16_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_ST_SP16) |=> busy[*3] ##1 done)
      else $error("long stack store cycle count wrong");
   a_st_io_size: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_ST_IO) |=> (code_size == move_pkg::SIZE_4 && mem.write && busy) ##1 done)
      else $error("io store size or timing wrong");
   a_absolute_mid_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_IMM_ABSOLUTE_MID) |=> busy[*2] ##1 done)
      else $error("absolute store cycle count wrong");
   a_ldw_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && (op_class == move_pkg::OP_LDW_SP8_DW || op_class == move_pkg::OP_LDW_SP8_A))
      |=> (mem.word && busy) ##1 busy[*2] ##1 done)
      else $error("word load cycle count wrong");
   a_stw_dw_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_STW_SP8_DW) |=> busy[*3] ##1 done)
      else $error("pair word store cycle count wrong");
   a_immw_a_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (take && op_class == move_pkg::OP_IMMW_A) |=> ##1 (done && areg[reg_sel[0]][15:8] == 8'h00))
      else $error("address immediate not zero extended");

   c_byte_load: cover property (@(posedge sys_clk) done && cur == move_pkg::OP_LD_SP8);
   c_word_store: cover property (@(posedge sys_clk) done && cur == move_pkg::OP_STW_SP8_DW);
   c_flag_load: cover property (@(posedge sys_clk) done && cur == move_pkg::OP_TO_FLAGS);
   c_io_store: cover property (@(posedge sys_clk) done && cur == move_pkg::OP_ST_IO);

endmodule

// ---- dv/mem_bus_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// memory and io bus model
// ************************************************************
module mem_bus_model (
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   input  wire move_pkg::mem_req_t mem,
   input  wire logic               done,
   output logic [15:0]             rdata
);
   logic        pend;
   logic [15:0] pat;

   // read pattern derived from the address
   assign pat = {~mem.addr[7:0], mem.addr[7:0] ^ mem.addr[15:8]};

   // a read is answered from its request until done
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 1'b0;
      end else if (mem.req && !mem.write) begin
         pend <= 1'b1;
      end else if (done) begin
         pend <= 1'b0;
      end
   end

   // outside a read the bus shows the inverse, never stale data
   assign rdata = ((mem.req && !mem.write) || pend) ? pat : ~pat;
endmodule

// ---- dv/byte_word_move_decoder_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ************************************************************
// bench
// ************************************************************
module byte_word_move_decoder_bench;
   logic               sys_clk, rst_b, start;
   logic [7:0]         op0, op1, imm;
   logic [15:0]        operand, stack_pointer, io_window_base, rdata;
   move_pkg::mem_req_t mem;
   logic               busy, done;
   logic [3:0]         code_size, flag_word, efl;
   logic [7:0]         data_reg0, data_reg1, data_reg2, data_reg3;
   logic [15:0]        addr_reg0, addr_reg1;
   logic [7:0]         dr [0:3];
   logic [15:0]        ar [0:1];
   logic [7:0]         ev [0:3];
   logic [15:0]        ea_r [0:1];
   int                 checks, failures;

   always_comb dr = '{data_reg0, data_reg1, data_reg2, data_reg3};
   always_comb ar = '{addr_reg0, addr_reg1};

   byte_word_move_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b), .start(start), .op0(op0), .op1(op1),
      .operand(operand), .imm(imm), .stack_pointer(stack_pointer), .io_window_base(io_window_base),
      .rdata(rdata), .mem(mem), .busy(busy), .done(done), .code_size(code_size), .data_reg0(data_reg0),
      .data_reg1(data_reg1), .data_reg2(data_reg2), .data_reg3(data_reg3), .addr_reg0(addr_reg0),
      .addr_reg1(addr_reg1), .flag_word(flag_word));

   mem_bus_model mdl (.sys_clk(sys_clk), .rst_b(rst_b), .mem(mem), .done(done), .rdata(rdata));

   // clock, 100 ns period
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // expected read pattern of the bus model
   function automatic logic [15:0] rd(input logic [15:0] a);
      return {~a[7:0], a[7:0] ^ a[15:8]};
   endfunction

   // issue one instruction, count cycles to done, check size and flags
   task automatic go(input logic [7:0] a, input logic [7:0] b, input logic [15:0] opd,
                     input logic [7:0] im, input int n, input logic [3:0] sz);
      int k;
      @(posedge sys_clk);
      start <= 1'b1;
      op0 <= a;
      op1 <= b;
      operand <= opd;
      imm <= im;
      @(posedge sys_clk);
      start <= 1'b0;
      k = 1; // the cycle holding start counts as the first
      do begin
         @(posedge sys_clk);
         #1 k++;
      end while (done !== 1'b1 && k < 9);
      `CHK({k[3:0], code_size}, {n[3:0], sz})
      `CHK(flag_word, efl)
   endtask

   // judge a byte load or store at the given address
   task automatic chk_b(input logic st, input logic [15:0] ea, input int r);
      logic [15:0] w;
      w = rd(ea);
      if (st) begin
         `CHK({mem.write, mem.addr, mem.wdata[7:0]}, {1'b1, ea, ev[r]})
      end else begin
         ev[r] = w[7:0];
         `CHK({mem.write, mem.addr, dr[r]}, {1'b0, ea, ev[r]})
      end
   endtask

   // word immediates, negative values show the extension
   task automatic t_imm_word;
      logic [7:0] im;
      for (int i = 0; i < 2; i++) begin
         im = {1'b1, i[0], 6'h1c};
         go({7'h06, i[0]}, 8'h00, 16'h0000, im, 2, 4'h4);
         ev[2*i] = im;
         ev[2*i+1] = 8'hff;
         `CHK({dr[2*i+1], dr[2*i]}, {8'hff, im})
         go({7'h07, i[0]}, 8'h00, 16'h0000, im, 2, 4'h4);
         ea_r[i] = {8'h00, im};
         `CHK(ar[i], ea_r[i])
      end
      $display("t_imm_word done");
   endtask

   // io window load into each register, then store from it
   task automatic t_io;
      for (int m = 0; m < 4; m++) begin
         go({6'h18, m[1:0]}, 8'h00, {8'h00, 6'h3f, m[1:0]}, 8'h00, 2, 4'h4);
         chk_b(1'b0, io_window_base + {8'h00, 6'h3f, m[1:0]}, m);
         go({6'h1c, m[1:0]}, 8'h00, {8'h00, 6'h00, m[1:0]}, 8'h00, 2, 4'h4);
         chk_b(1'b1, io_window_base + {14'h0000, m[1:0]}, m);
      end
      $display("t_io done");
   endtask

   // data register into the flag word, later moves leave it
   task automatic t_flags;
      for (int r = 3; r >= 0; r--) begin
         efl = ev[r][3:0];
         go(8'h29, {6'h01, r[1:0]}, 16'h0000, 8'h00, 3, 4'h3);
      end
      $display("t_flags done");
   endtask

   // stack relative byte moves, short offset zero extended
   task automatic t_sp;
      logic [15:0] opd, ea;
      for (int k = 0; k < 8; k++) begin
         opd = {14'h3ffe, k[1:0]};
         ea = stack_pointer + (k[0] ? opd : {8'h00, opd[7:0]});
         go({7'h13, k[2]}, {5'h00, ~k[0], k[1:0]}, opd, 8'h00, k[0] ? 4 : 3, k[0] ? 4'h7 : 4'h5);
         chk_b(k[2], ea, k[1:0]);
      end
      $display("t_sp done");
   endtask

   // address register plus long displacement
   task automatic t_ad16;
      logic [15:0] opd;
      for (int k = 0; k < 8; k++) begin
         opd = {14'h0a00, k[1:0]};
         go({7'h13, k[2]}, {4'h0, 1'b1, k[0], k[1:0]}, opd, 8'h00, 4, 4'h7);
         chk_b(k[2], ea_r[k[0]] + opd, k[1:0]);
      end
      $display("t_ad16 done");
   endtask

   // immediates to the io window and to a 12-bit address
   task automatic t_imm;
      go(8'h02, 8'h00, 16'h0077, 8'ha5, 3, 4'h6);
      `CHK({mem.write, mem.addr, mem.wdata[7:0]}, {1'b1, io_window_base + 16'h0077, 8'ha5})
      go(8'h15, 8'h00, 16'hfabc, 8'h3c, 3, 4'h7);
      `CHK({mem.write, mem.addr, mem.wdata[7:0]}, {1'b1, 16'h0abc, 8'h3c})
      $display("t_imm done");
   endtask

   // word loads and stores through the stack pointer
   task automatic t_word;
      logic [15:0] ea, w;
      for (int d = 0; d < 2; d++) begin
         ea = stack_pointer + 16'h0080 + d[15:0];
         go(8'h2e, {7'h03, d[0]}, 16'hff80 + d[15:0], 8'h00, 4, 4'h5);
         w = rd(ea);
         ev[2*d] = w[7:0];
         ev[2*d+1] = w[15:8];
         `CHK({mem.write, mem.word, mem.addr, dr[2*d+1], dr[2*d]}, {2'b01, ea, w})
         ea = stack_pointer + 16'h0090 + d[15:0];
         go(8'h2e, {7'h02, d[0]}, 16'hff90 + d[15:0], 8'h00, 4, 4'h5);
         ea_r[d] = rd(ea);
         `CHK({mem.write, mem.word, mem.addr, ar[d]}, {2'b01, ea, ea_r[d]})
      end
      for (int d = 0; d < 2; d++) begin
         go(8'h2f, {7'h03, d[0]}, 16'h0022, 8'h00, 4, 4'h5);
         `CHK({mem.write, mem.word, mem.addr, mem.wdata}, {2'b11, stack_pointer + 16'h0022, ev[2*d+1], ev[2*d]})
         go(8'h2f, {7'h00, d[0]}, 16'hf000, 8'h00, 5, 4'h7);
         `CHK({mem.write, mem.word, mem.addr, mem.wdata}, {2'b11, stack_pointer + 16'hf000, ea_r[d]})
      end
      $display("t_word done");
   endtask

   // verdict and end of run
   task tally_and_finish;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst_b = 1'b0;
      start = 1'b0;
      op0 = 8'h00;
      op1 = 8'h00;
      operand = 16'h0000;
      imm = 8'h00;
      stack_pointer = 16'h1200;
      io_window_base = 16'h3f00;
      efl = 4'h0;
      checks = 0;
      failures = 0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_imm_word;
      t_io;
      t_flags;
      t_sp;
      t_ad16;
      t_imm;
      t_word;
      tally_and_finish;
   end

   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      $display("watchdog expired");
      tally_and_finish;
   end
endmodule
